/* logic/dlc_cfg.svh */
`ifndef DLC_CFG_SVH
`define DLC_CFG_SVH
// Register byte offsets
`define DLC_OFS_CTRL 8'h00
`define DLC_OFS_STATUS 8'h04
`define DLC_OFS_KEY 8'h08
`define DLC_OFS_COUNT 8'h0C
`define DLC_OFS_ERRCODE 8'h10
`define DLC_OFS_LIMIT 8'h14
`define DLC_OFS_PERIOD 8'h18
`define DLC_OFS_CFG 8'h1C
`define DLC_OFS_IRQ_STAT 8'h20
`define DLC_OFS_IRQ_CLR 8'h24
`define DLC_OFS_IRQ_EN 8'h28
// Control fields
`define DLC_CTRL_REC 0
`define DLC_CTRL_SAVE 1
// Config fields
`define DLC_CFG_TRIG_MODE 0
`define DLC_CFG_CONTINUE 1
`define DLC_CFG_VALID 2
// Status fields
`define DLC_ST_PRESENT 0
`define DLC_ST_SAVING 1
`define DLC_ST_ERROR 2
`define DLC_ST_LIMIT 3
`define DLC_ST_VALID 4
`define DLC_ST_RECORDING 5
// Interrupt event bits
`define DLC_EV_RECORD 0
`define DLC_EV_LIMIT 1
`define DLC_EV_SAVE_DONE 2
`define DLC_EV_ERROR 3
`define DLC_EV_W 4
// Values
`define DLC_SAVE_KEY 16'h5AA5
`define DLC_LIMIT_RST 32'h0000_03E8
`define DLC_PERIOD_RST 16'h0001
// One second at 200 MHz
`define DLC_CLK_HZ 200000000
`define DLC_SEC_TICKS (`DLC_CLK_HZ)
`endif

/* logic/dlc_pkg.sv */
package dlc_pkg;
    typedef enum logic [1:0] {
        DLC_IDLE,
        DLC_SAVE_REQ,
        DLC_SAVE_WAIT
    } dlc_state_type;

    typedef struct packed {
        logic [7:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic req;
    } dlc_wb_req_type;

    typedef struct packed {
        logic done;
        logic error;
        logic [15:0] code;
    } dlc_card_rsp_type;
endpackage : dlc_pkg

/* logic/dlc_logger.sv */
// Contract
// (RL1) With continue option, recording goes on past the limit, overwriting oldest records.
// (RL2) Parameters-valid flag set only after a valid parameter set is loaded.
// (RL3) Recording runs while record-enable is set; hardware never clears it.
// (RL4) Save-trigger rising edge starts a card save when the key matches.
// (RL5) Any other key value is invalid; no save happens.
// (RL6) Save begins when limit flag is on or count equals configured quantity.
// (RL7) Limit flag on when count reaches quantity or in cyclic recording.
// (RL8) Record counter, 32 bits, increments by one per captured record.
// (RL9) Saving flag held on for the whole card write, off otherwise.
// (RL10) Card-error flag set on failed card operation, cleared when normal.
// (RL11) Last card error code held read-only; meaningful while error flag on.
// (RL12) Card-present flag follows card insertion.
// (RL13) Interrupts blocked during card transfer; program must avoid pending ones.
// (RL14) Samples taken periodically in seconds or on a trigger bit.
// (RL15) With stop option, capture halts at the limit until restarted.
`include "dlc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dlc_logger #(
    parameter int SEC_TICKS = `DLC_SEC_TICKS
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic trig_bit_i, // Sampling trigger bit
    output logic sample_o, // Pulse: capture one record now
    input wire logic card_present_i, // Card inserted
    output logic card_start_o, // Pulse: begin card write
    input wire logic card_done_i, // Pulse: card write finished
    input wire logic card_fail_i, // With done: write failed
    input wire logic [15:0] card_code_i, // Error code with done
    output logic irq_block_o, // High while interrupts must be held off
    output logic irq_o // Level interrupt
);
    dlc_pkg::dlc_wb_req_type bus;
    dlc_pkg::dlc_card_rsp_type card;
    dlc_pkg::dlc_state_type state_reg, state_next;

    logic ack_reg;
    logic [31:0] rdata_reg;
    logic rec_en_reg, save_trig_reg, save_trig_d_reg;
    logic [15:0] key_reg;
    logic [31:0] limit_reg, count_reg;
    logic [15:0] period_reg;
    logic trig_mode_reg, continue_reg, valid_reg;
    logic limit_hit_reg, wrapped_reg;
    logic error_reg;
    logic [15:0] err_code_reg;
    logic trig_d_reg;
    logic [31:0] tick_reg;
    logic [15:0] sec_reg;
    logic [`DLC_EV_W-1:0] irq_stat_reg, irq_en_reg;
    logic count_match_reg;

    function automatic logic [31:0] merge_word(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_word

    assign bus = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i,
                   req: wb_cyc_i & wb_stb_i & ~ack_reg};
    assign card = '{done: card_done_i, error: card_fail_i, code: card_code_i};

    wire wr = bus.req & bus.we;
    wire rd = bus.req & ~bus.we;
    wire wr_ctrl = wr && bus.adr == `DLC_OFS_CTRL;
    wire wr_key = wr && bus.adr == `DLC_OFS_KEY;
    wire wr_limit = wr && bus.adr == `DLC_OFS_LIMIT;
    wire wr_period = wr && bus.adr == `DLC_OFS_PERIOD;
    wire wr_cfg = wr && bus.adr == `DLC_OFS_CFG;
    wire wr_iclr = wr && bus.adr == `DLC_OFS_IRQ_CLR;
    wire wr_ien = wr && bus.adr == `DLC_OFS_IRQ_EN;
    wire [31:0] ctrl_new = merge_word({30'h0, save_trig_reg, rec_en_reg}, bus.dat, bus.sel);
    wire [31:0] cfg_new = merge_word({29'h0, valid_reg, continue_reg, trig_mode_reg},
                                     bus.dat, bus.sel);

    wire saving = state_reg != dlc_pkg::DLC_IDLE;
    // Stop option freezes capture at the limit; continue keeps going
    wire capture_ok = rec_en_reg & valid_reg & ~saving & (continue_reg | ~limit_hit_reg); // (RL3) (RL15) (RL1)
    wire sec_tick = tick_reg == 32'(SEC_TICKS - 1);
    wire period_due = sec_tick && sec_reg + 16'h1 >= period_reg;
    wire trig_edge = trig_bit_i & ~trig_d_reg;
    wire sample = capture_ok & (trig_mode_reg ? trig_edge : period_due); // (RL14)
    wire at_limit = count_reg + 32'h1 == limit_reg;
    wire key_ok = key_reg == `DLC_SAVE_KEY; // (RL5)
    wire save_edge = save_trig_reg & ~save_trig_d_reg; // (RL4)
    // Limit hit or count match also start a save, but only with a valid key
    wire auto_save = (limit_hit_reg | count_match_reg) & key_ok; // (RL6)
    wire save_go = ~saving & card_present_i & key_ok & (save_edge | auto_save); // (RL4) (RL6)
    wire limit_flag = limit_hit_reg | wrapped_reg; // (RL7)
    // A late done after the card was pulled must not raise a save event
    wire card_end = card.done && state_reg == dlc_pkg::DLC_SAVE_WAIT;
    wire [`DLC_EV_W-1:0] events = {card_end & card.error,
                                   card_end & ~card.error,
                                   sample & at_limit, sample};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dlc_pkg::DLC_IDLE: begin
                if (save_go) begin
                    state_next = dlc_pkg::DLC_SAVE_REQ;
                end
            end
            dlc_pkg::DLC_SAVE_REQ: begin
                state_next = dlc_pkg::DLC_SAVE_WAIT;
            end
            dlc_pkg::DLC_SAVE_WAIT: begin
                if (card.done || !card_present_i) begin
                    state_next = dlc_pkg::DLC_IDLE;
                end
            end
            default: begin
                state_next = dlc_pkg::DLC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= dlc_pkg::DLC_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus slave: one wait state, ack then drop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg <= bus.req;
            if (rd) begin
                case (bus.adr)
                    `DLC_OFS_CTRL: rdata_reg <= {30'h0, save_trig_reg, rec_en_reg};
                    `DLC_OFS_STATUS: rdata_reg <= {26'h0, rec_en_reg, valid_reg, limit_flag,
                                                   error_reg, saving, card_present_i}; // (RL12) (RL9) (RL2)
                    `DLC_OFS_KEY: rdata_reg <= {16'h0, key_reg};
                    `DLC_OFS_COUNT: rdata_reg <= count_reg;
                    `DLC_OFS_ERRCODE: rdata_reg <= {16'h0, err_code_reg}; // (RL11)
                    `DLC_OFS_LIMIT: rdata_reg <= limit_reg;
                    `DLC_OFS_PERIOD: rdata_reg <= {16'h0, period_reg};
                    `DLC_OFS_CFG: rdata_reg <= {29'h0, valid_reg, continue_reg, trig_mode_reg};
                    `DLC_OFS_IRQ_STAT: rdata_reg <= {28'h0, irq_stat_reg};
                    `DLC_OFS_IRQ_EN: rdata_reg <= {28'h0, irq_en_reg};
                    default: rdata_reg <= 32'h0;
                endcase
            end
        end
    end

    // Software registers; the record-enable bit is only ever written by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rec_en_reg <= 1'b0;
            save_trig_reg <= 1'b0;
            save_trig_d_reg <= 1'b0;
            key_reg <= 16'h0;
            limit_reg <= `DLC_LIMIT_RST;
            period_reg <= `DLC_PERIOD_RST;
            trig_mode_reg <= 1'b0;
            continue_reg <= 1'b0;
            valid_reg <= 1'b0;
            irq_en_reg <= '0;
        end else begin
            save_trig_d_reg <= save_trig_reg;
            if (wr_ctrl) begin
                rec_en_reg <= ctrl_new[`DLC_CTRL_REC]; // (RL3)
                save_trig_reg <= ctrl_new[`DLC_CTRL_SAVE];
            end
            if (wr_key) begin
                key_reg <= 16'(merge_word({16'h0, key_reg}, bus.dat, bus.sel));
            end
            if (wr_limit) begin
                limit_reg <= merge_word(limit_reg, bus.dat, bus.sel);
            end
            if (wr_period) begin
                period_reg <= 16'(merge_word({16'h0, period_reg}, bus.dat, bus.sel));
            end
            // Valid only for a nonzero limit and period
            if (wr_cfg) begin
                trig_mode_reg <= cfg_new[`DLC_CFG_TRIG_MODE];
                continue_reg <= cfg_new[`DLC_CFG_CONTINUE];
                valid_reg <= cfg_new[`DLC_CFG_VALID] && limit_reg != 32'h0
                             && period_reg != 16'h0; // (RL2)
            end else if (wr_limit || wr_period) begin
                valid_reg <= 1'b0; // (RL2)
            end
            if (wr_ien) begin
                irq_en_reg <= bus.dat[`DLC_EV_W-1:0];
            end
        end
    end

    // Sampling, counting and limit tracking
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_d_reg <= 1'b0;
            tick_reg <= 32'h0;
            sec_reg <= 16'h0;
            count_reg <= 32'h0;
            limit_hit_reg <= 1'b0;
            wrapped_reg <= 1'b0;
            count_match_reg <= 1'b0;
        end else begin
            trig_d_reg <= trig_bit_i;
            tick_reg <= sec_tick ? 32'h0 : tick_reg + 32'h1;
            if (period_due || !capture_ok) begin
                sec_reg <= 16'h0;
            end else if (sec_tick) begin
                sec_reg <= sec_reg + 16'h1;
            end
            // A new match in the cycle a save starts is kept, not lost
            if (save_go) begin
                count_match_reg <= 1'b0;
            end
            if (sample) begin
                count_reg <= count_reg + 32'h1; // (RL8)
                if (at_limit) begin
                    limit_hit_reg <= 1'b1; // (RL7)
                    count_match_reg <= 1'b1; // (RL6)
                    wrapped_reg <= continue_reg; // (RL1)
                end
            end
            // Restart: re-enabling recording or reloading parameters rearms the limit
            // A stale match from the last run must not launch a save on the next key write
            if ((wr_ctrl && ctrl_new[`DLC_CTRL_REC] && !rec_en_reg) || wr_cfg) begin
                limit_hit_reg <= 1'b0; // (RL15)
                wrapped_reg <= 1'b0;
                count_match_reg <= 1'b0;
                count_reg <= 32'h0;
            end
        end
    end

    // Card error flag and code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_reg <= 1'b0;
            err_code_reg <= 16'h0;
        end else if (card.done && state_reg == dlc_pkg::DLC_SAVE_WAIT) begin
            error_reg <= card.error; // (RL10)
            if (card.error) begin
                err_code_reg <= card.code; // (RL11)
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_iclr ? bus.dat[`DLC_EV_W-1:0] : '0)) | events;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign sample_o = sample;
    assign card_start_o = state_reg == dlc_pkg::DLC_SAVE_REQ;
    // Interrupt delivery held off through the whole card transfer
    assign irq_block_o = saving; // (RL13)
    assign irq_o = |(irq_stat_reg & irq_en_reg) & ~saving; // (RL13)
endmodule : dlc_logger
`default_nettype wire

/* sim/dlc_card_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dlc_card_model (
    input wire logic clk_i, // Clock
    input wire logic start_i, // Write start pulse
    input wire logic fail_i, // Fail the next write
    input wire logic [7:0] delay_i, // Write time in cycles
    input wire logic [15:0] code_i, // Code to report
    output logic done_o, // Write finished pulse
    output logic fail_o, // Failure, valid with done
    output logic [15:0] code_o // Code, valid with done
);
    int cnt = 0;
    // Outside done the lines wander so a stale value is never trusted
    logic [15:0] junk = 16'hA5C3;
    always @(posedge clk_i) begin
        junk <= ~junk ^ 16'h0101;
        if (start_i) cnt <= delay_i;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    assign done_o = (cnt == 1);
    assign fail_o = done_o ? fail_i : junk[0];
    assign code_o = done_o ? code_i : junk;
endmodule : dlc_card_model
`default_nettype wire

/* sim/dlc_logger_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dlc_logger_chk #(
    parameter int SEC_TICKS = 10
) (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Acknowledge
    input wire logic sample_o, // Record pulse
    input wire logic card_present_i, // Card in
    input wire logic card_start_o, // Write start
    input wire logic card_done_i, // Write done
    input wire logic irq_block_o, // Interrupt hold-off
    input wire logic irq_o // Interrupt
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_start_card: assert property (card_start_o |-> $past(card_present_i))
        else $error("write started without card");
    a_block_rise: assert property ($rose(irq_block_o) |-> card_start_o)
        else $error("saving without start");
    a_block_hold: assert property (irq_block_o && !card_done_i && card_present_i |=> irq_block_o)
        else $error("saving dropped early");
    a_done_ends: assert property (irq_block_o && card_done_i |=> !irq_block_o)
        else $error("saving outlived done");
    a_irq_held: assert property (irq_block_o |-> !irq_o)
        else $error("interrupt during card write");
    a_sample_idle: assert property (sample_o |-> !irq_block_o)
        else $error("record taken while saving");
    a_start_single: assert property (card_start_o |=> !card_start_o && irq_block_o)
        else $error("start not single or not saving");
    c_start: cover property (card_start_o);
    c_sample: cover property (sample_o);
    c_irq: cover property (irq_o);
    c_done: cover property (irq_block_o && card_done_i);
endmodule : dlc_logger_chk
bind dlc_logger dlc_logger_chk #(.SEC_TICKS(SEC_TICKS)) i_dlc_logger_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sample_o(sample_o), .card_present_i(card_present_i),
    .card_start_o(card_start_o), .card_done_i(card_done_i),
    .irq_block_o(irq_block_o), .irq_o(irq_o));
`default_nettype wire

/* sim/dlc_logger_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dlc_logger_test;
    logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, trig = 0, pres = 1, fcmd = 0;
    logic done, fail, ack, smp, start, blk, irq;
    logic [7:0] adr = 8'h00, dly = 8'h10;
    logic [31:0] dat = 32'h0, rdat;
    logic [15:0] code, ccmd = 16'h0, bad;
    logic [31:0] exp_q[$];
    int n_fail = 0, tests_run = 0;
    int wait_n, gap;
    logic [3:0] sel = 4'hF;
    dlc_logger #(.SEC_TICKS(10)) i_dlc_logger (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .trig_bit_i(trig), .sample_o(smp),
        .card_present_i(pres), .card_start_o(start), .card_done_i(done),
        .card_fail_i(fail), .card_code_i(code), .irq_block_o(blk), .irq_o(irq));
    dlc_card_model i_dlc_card_model (.clk_i(clk_i), .start_i(start), .fail_i(fcmd),
        .delay_i(dly), .code_i(ccmd), .done_o(done), .fail_o(fail), .code_o(code));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task automatic timeout;
        check(32'h0, 32'h1);
        report_and_stop();
    endtask : timeout
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) timeout();
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse(input int k);
        repeat (k) begin
            trig <= 1'b1;
            repeat (2) @(posedge clk_i);
            trig <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : pulse
    // Key is dropped right after start so a set limit flag cannot relaunch
    task automatic save_run(input logic [31:0] st);
        int n;
        n = 0;
        while (start !== 1'b1 && n < 30) begin
            @(posedge clk_i);
            n++;
        end
        if (start !== 1'b1) timeout();
        wb(1'b1, 8'h08, 32'h0);
        rd(8'h04, st);
        n = 0;
        while (blk !== 1'b0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        if (blk !== 1'b0) timeout();
        @(posedge clk_i);
    endtask : save_run
    always @(posedge clk_i) if (ack === 1'b1 && !we && exp_q.size() > 0) check(rdat, exp_q.pop_front());
    initial forever #2.5 clk_i = ~clk_i;
    initial begin
        #500000;
        timeout();
    end
    initial begin
        void'($urandom(78219));
        bad = 16'($urandom);
        if (bad == 16'h5AA5) bad = 16'h5AA4;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h14, 32'h0000_03E8);
        rd(8'h18, 32'h0000_0001);
        rd(8'h40, 32'h0);
        rd(8'h04, 32'h01);
        wb(1'b1, 8'h14, 32'h3);
        wb(1'b1, 8'h1C, 32'h5);
        rd(8'h04, 32'h11);
        wb(1'b1, 8'h00, 32'h1);
        pulse(2);
        rd(8'h0C, 32'h2);
        pulse(2);
        rd(8'h0C, 32'h3);
        rd(8'h04, 32'h39);
        rd(8'h00, 32'h1);
        wb(1'b1, 8'h08, {16'h0, bad});
        wb(1'b1, 8'h00, 32'h3);
        repeat (4) @(posedge clk_i);
        rd(8'h04, 32'h39);
        wb(1'b1, 8'h00, 32'h1);
        wb(1'b1, 8'h24, 32'hF);
        wb(1'b1, 8'h28, 32'h4);
        dly <= 8'd12 + 8'($urandom % 16);
        wb(1'b1, 8'h08, 32'h5AA5);
        save_run(32'h3B);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h28, 32'h0);
        check({31'h0, irq}, 32'h0);
        wb(1'b1, 8'h28, 32'h4);
        check({31'h0, irq}, 32'h1);
        wb(1'b1, 8'h24, 32'h4);
        check({31'h0, irq}, 32'h0);
        fcmd <= 1'b1;
        ccmd <= 16'($urandom);
        wb(1'b1, 8'h08, 32'h5AA5);
        save_run(32'h3B);
        rd(8'h04, 32'h3D);
        rd(8'h10, {16'h0, ccmd});
        wb(1'b1, 8'h1C, 32'h7);
        pulse(4);
        rd(8'h0C, 32'h4);
        rd(8'h04, 32'h3D);
        fcmd <= 1'b0;
        wb(1'b1, 8'h1C, 32'h5);
        wb(1'b1, 8'h08, 32'h5AA5);
        wb(1'b1, 8'h00, 32'h3);
        save_run(32'h37);
        rd(8'h04, 32'h31);
        pres <= 1'b0;
        @(posedge clk_i);
        rd(8'h04, 32'h30);
        sel <= 4'h1;
        wb(1'b1, 8'h14, 32'hFFFF_FF05);
        sel <= 4'hF;
        rd(8'h14, 32'h0000_0005);
        wb(1'b1, 8'h18, 32'h2);
        wb(1'b1, 8'h1C, 32'h4);
        wait_n = 0;
        while (smp !== 1'b1 && wait_n < 40) begin
            @(posedge clk_i);
            wait_n++;
        end
        if (smp !== 1'b1) timeout();
        gap = 0;
        do begin
            @(posedge clk_i);
            gap++;
        end while (smp !== 1'b1 && gap < 40);
        check(gap, 32'd20);
        repeat (3) @(posedge clk_i);
        report_and_stop();
    end
endmodule : dlc_logger_test
`default_nettype wire
